// ==== verilog/lfs_status_regs.sv ====
// Purpose: Read-only live fault and status registers of the diagnostic logic.
// Assumes: Detector inputs are synchronous to ref_clk_in; reads are single
//          cycle strobes with an address from the control port.
// Notes:   All three registers follow their conditions live; nothing latches.
`timescale 1ns/10ps
`include "lfs_defs.svh"

module lfs_status_regs #(
    parameter int NUM_CHAN = 4,  // Channels with a live fault byte.
    parameter int WIDTH    = 8   // Bits in each register.
) (
    input  wire logic                ref_clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                serial_clk_err_in,
    input  wire logic                pll_lock_in,
    input  wire logic                over_temp_in,
    input  wire logic                over_curr_in,
    input  wire logic [NUM_CHAN-1:0] vbat_low_short_in,
    input  wire logic [WIDTH-1:0]    chan1_faults_in,
    input  wire logic [WIDTH-1:0]    chan2_faults_in,
    input  wire logic [WIDTH-1:0]    chan3_faults_in,
    input  wire logic [WIDTH-1:0]    chan4_faults_in,
    input  wire logic                reg_rd_in,
    input  wire logic [7:0]          reg_addr_in,
    output logic      [WIDTH-1:0]    reg_rdata_out,
    output logic                     reg_rvalid_out
);

    // ------------------------------------------------------------------
    // Per-channel live fault bytes
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] chan_faults [NUM_CHAN];  // Raw detector bytes by channel.
    logic [WIDTH-1:0] chan_live   [NUM_CHAN];  // Stored live bytes by channel.
    logic [NUM_CHAN-1:0] chan_any;             // Any-fault flag by channel.

    // Gather the separate channel ports into one array for the loop.
    assign chan_faults[0] = chan1_faults_in;
    assign chan_faults[1] = chan2_faults_in;
    assign chan_faults[2] = chan3_faults_in;
    assign chan_faults[3] = chan4_faults_in;

    // One live byte per channel, each with its own summary flag.
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
        lfs_chan_fault #(
            .WIDTH (WIDTH)
        ) u_chan (
            .ref_clk_in (ref_clk_in),
            .rst_n_in   (rst_n_in),
            .faults_in  (chan_faults[g]),
            .live_out   (chan_live[g]),
            .any_out    (chan_any[g])
        );
    end

    // ------------------------------------------------------------------
    // Global live status and low-battery short state
    // ------------------------------------------------------------------
    lfs_pkg::lfs_byte_t global_reg;   // Global live status.
    lfs_pkg::lfs_byte_t global_next;  // Next global live status.
    logic               vbat_reg;     // Low-battery short seen somewhere.
    logic               vbat_next;    // Next low-battery short state.

    // Place each live condition at its bit; reserved bits stay zero.
    always_comb begin
        global_next                     = `LFS_RESET_BYTE;
        global_next[`LFS_GBIT_SER_ERR]  = serial_clk_err_in;
        global_next[`LFS_GBIT_PLL_LOCK] = pll_lock_in;
        global_next[`LFS_GBIT_OVR_TEMP] = over_temp_in;
        global_next[`LFS_GBIT_OVR_CURR] = over_curr_in;
        vbat_next                       = |vbat_low_short_in;
    end

    // Synchronous reset clears the live state.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            global_reg <= `LFS_RESET_BYTE;
            vbat_reg   <= 1'b0;
        end else begin
            global_reg <= global_next;
            vbat_reg   <= vbat_next;
        end
    end

    // ------------------------------------------------------------------
    // Channel fault summary
    // ------------------------------------------------------------------
    lfs_pkg::lfs_byte_t summary;  // Summary byte, built from stored state.

    // Channel 1 sits at the top bit and later channels step downward.
    always_comb begin
        summary = `LFS_RESET_BYTE;
        for (int i = 0; i < NUM_CHAN; i++) begin
            summary[`LFS_SBIT_CH1 - i] = chan_any[i];
        end
        summary[`LFS_SBIT_VBAT_LOW] = vbat_reg;
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    lfs_pkg::lfs_byte_t rdata_reg;   // Read data held for the control port.
    lfs_pkg::lfs_byte_t rdata_next;  // Next read data.
    logic               rvalid_reg;  // Read data valid, one cycle.
    logic               rvalid_next; // Next read data valid.

    // Select the addressed register; data holds between reads.
    always_comb begin
        rdata_next  = rdata_reg;
        rvalid_next = reg_rd_in;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `LFS_ADDR_GLOBAL:  rdata_next = global_reg;
                `LFS_ADDR_SUMMARY: rdata_next = summary;
                `LFS_ADDR_CHAN1:   rdata_next = chan_live[0];
                default:           rdata_next = `LFS_UNMAPPED_BYTE;
            endcase
        end
    end

    // Synchronous reset clears the read port.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rdata_reg  <= `LFS_RESET_BYTE;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata_out  = rdata_reg;
    assign reg_rvalid_out = rvalid_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // A read of a given address in this cycle.
    sequence rd_global_s;
        reg_rd_in && reg_addr_in == `LFS_ADDR_GLOBAL;
    endsequence
    sequence rd_summary_s;
        reg_rd_in && reg_addr_in == `LFS_ADDR_SUMMARY;
    endsequence
    sequence rd_chan1_s;
        reg_rd_in && reg_addr_in == `LFS_ADDR_CHAN1;
    endsequence

    // On the first cycle out of reset the global register and the read port show zero.
    reset_zero_a: assert property ($rose(rst_n_in) |-> global_reg == `LFS_RESET_BYTE &&
        reg_rdata_out == `LFS_RESET_BYTE && !reg_rvalid_out)
        else $error("global status not zero after reset");

    // Read data shows the input from the cycle before the read, or zero if reset held then.
    serial_err_bit_a: assert property (rd_global_s |=>
        reg_rvalid_out && reg_rdata_out[`LFS_GBIT_SER_ERR] == $past(serial_clk_err_in && rst_n_in, 2))
        else $error("serial clock error bit wrong");

    // Lock bit follows the lock detector.
    pll_lock_bit_a: assert property (rd_global_s |=>
        reg_rdata_out[`LFS_GBIT_PLL_LOCK] == $past(pll_lock_in && rst_n_in, 2))
        else $error("pll lock bit wrong");

    // Over-temperature bit follows its detector.
    over_temp_bit_a: assert property (rd_global_s |=>
        reg_rdata_out[`LFS_GBIT_OVR_TEMP] == $past(over_temp_in && rst_n_in, 2))
        else $error("over temperature bit wrong");

    // Over-current bit follows its detector.
    over_curr_bit_a: assert property (rd_global_s |=>
        reg_rdata_out[`LFS_GBIT_OVR_CURR] == $past(over_curr_in && rst_n_in, 2))
        else $error("over current bit wrong");

    // Reserved bits of both status bytes read as zero.
    reserved_zero_a: assert property ((rd_global_s |=> reg_rdata_out[3:0] == 4'h0) and
        (rd_summary_s |=> reg_rdata_out[3:2] == 2'h0 && !reg_rdata_out[0]))
        else $error("reserved bit reads one");

    // Channel 1 summary bit reads as the OR of that channel's faults.
    chan1_sum_a: assert property (rd_summary_s |=>
        reg_rdata_out[`LFS_SBIT_CH1] == (|$past(chan1_faults_in, 2) && $past(rst_n_in, 2)))
        else $error("channel 1 summary bit wrong");

    // Low-battery short bit reads set when any channel reported it.
    vbat_low_bit_a: assert property (rd_summary_s |=>
        reg_rdata_out[`LFS_SBIT_VBAT_LOW] == (|$past(vbat_low_short_in, 2) && $past(rst_n_in, 2)))
        else $error("low battery short bit wrong");

    // Channel 1 byte reads back every fault condition in place.
    chan1_byte_a: assert property (rd_chan1_s |=>
        reg_rdata_out == $past(chan1_faults_in & {WIDTH{rst_n_in}}, 2))
        else $error("channel 1 fault byte wrong");

    // Open input and pair short land on the top two bits.
    open_pair_bits_a: assert property (rd_chan1_s |=>
        reg_rdata_out[7:6] == $past(chan1_faults_in[7:6] & {2{rst_n_in}}, 2))
        else $error("open or pair short bit wrong");

    // Ground, bias and battery shorts land on bits 5 to 0.
    short_bits_a: assert property (rd_chan1_s |=>
        reg_rdata_out[5:0] == $past(chan1_faults_in[5:0] & {6{rst_n_in}}, 2))
        else $error("short fault bits wrong");

    // Fourth channel summary shows its detector byte one edge on, with no extra delay.
    chan4_same_cycle_a: assert property (
        summary[`LFS_SBIT_CH1 - 3] == (|$past(chan4_faults_in) && $past(rst_n_in)))
        else $error("channel 4 summary lags its byte");

endmodule

// ==== common/lfs_defs.svh ====
// Purpose: Constants for the live fault and status register group.
// Assumes: Byte-wide registers reached through an 8-bit register address.
// Notes:   Offsets, field positions and reset values live here only.
`ifndef LFS_DEFS_SVH
`define LFS_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LFS_ADDR_GLOBAL   8'h2C
`define LFS_ADDR_SUMMARY  8'h2D
`define LFS_ADDR_CHAN1    8'h2E

// ----------------------------------------------------------------------
// Reset and idle values
// ----------------------------------------------------------------------
`define LFS_RESET_BYTE    8'h00
`define LFS_UNMAPPED_BYTE 8'h00

// ----------------------------------------------------------------------
// Global live status field positions
// ----------------------------------------------------------------------
`define LFS_GBIT_SER_ERR  7
`define LFS_GBIT_PLL_LOCK 6
`define LFS_GBIT_OVR_TEMP 5
`define LFS_GBIT_OVR_CURR 4

// ----------------------------------------------------------------------
// Channel fault summary field positions
// ----------------------------------------------------------------------
`define LFS_SBIT_CH1      7
`define LFS_SBIT_VBAT_LOW 1

`endif

// ==== common/lfs_pkg.sv ====
// Purpose: Shared types for the live fault and status register group.
// Assumes: Byte-wide register data and addresses.
// Notes:   Constants sit in lfs_defs.svh; this package holds types only.
package lfs_pkg;

    // One register byte.
    typedef logic [7:0] lfs_byte_t;

    // One register address.
    typedef logic [7:0] lfs_addr_t;

endpackage

// ==== verilog/lfs_chan_fault.sv ====
// Purpose: Live fault byte of one input channel and its any-fault summary.
// Assumes: Fault inputs are synchronous to ref_clk_in.
// Notes:   The summary follows the stored byte in the same cycle.
`timescale 1ns/10ps
`include "lfs_defs.svh"

module lfs_chan_fault #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] faults_in,
    output logic      [WIDTH-1:0] live_out,
    output logic                  any_out
);

    // ------------------------------------------------------------------
    // Live fault byte
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] live_reg;   // Stored live conditions.
    logic [WIDTH-1:0] live_next;  // Next stored value.

    // The byte simply tracks the detectors, one bit per condition.
    always_comb begin
        live_next = faults_in;
    end

    // Synchronous reset clears every condition.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            live_reg <= WIDTH'(`LFS_RESET_BYTE);
        end else begin
            live_reg <= live_next;
        end
    end

    assign live_out = live_reg;
    // Any set bit marks the channel as faulted, with no extra delay.
    assign any_out  = |live_reg;

endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the live fault and status register group.
// Assumes: Inputs change at the falling edge; reads are single-cycle strobes.
// Notes:   A cycle model of the block predicts every read; stimulus is seeded.
`timescale 1ns/10ps
`include "lfs_defs.svh"

// Counts one comparison and reports a mismatch on the spot.
`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module tb;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic               ref_clk_in = 1'h0;   // Bench clock, 100 ns period.
    logic               rst_n_in;            // Synchronous reset, low active.
    logic [39:0]        in_v;                // Global, low battery and channel bytes.
    logic               reg_rd_in;           // Read strobe.
    logic [7:0]         reg_addr_in;         // Read address.
    lfs_pkg::lfs_byte_t reg_rdata_out;       // Read data from the block.
    logic               reg_rvalid_out;      // Read valid pulse from the block.
    int                 err_count = 0;       // Mismatches seen.
    int                 checks_done = 0;     // Comparisons made.
    integer             seed = 16906;        // Fixed seed keeps runs repeatable.
    logic [39:0]        st_m = 40'h0;        // Model of the stored detector levels.
    lfs_pkg::lfs_byte_t rdat_m = 8'h00;      // Model of the held read data.
    logic               rv_m = 1'h0;         // Model of the valid pulse.
    logic [7:0]         addr_m = 8'h00;      // Address of the last modelled read.
    logic [7:0]         ad;                  // Address picked for the next random read.
    logic [63:0]        ra;                  // Random word.
    logic [63:0]        rb;                  // Second random word for sparse faults.
    logic [7:0]         addr_tab [0:7] = '{`LFS_ADDR_GLOBAL, `LFS_ADDR_SUMMARY, `LFS_ADDR_CHAN1,
        `LFS_ADDR_GLOBAL, `LFS_ADDR_SUMMARY, `LFS_ADDR_CHAN1, 8'h2F, 8'h2B};

    // Clock toggles every half period.
    always #50 ref_clk_in = ~ref_clk_in;

    // ------------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------------
    lfs_status_regs i_lfs_status_regs (
        .ref_clk_in        (ref_clk_in),
        .rst_n_in          (rst_n_in),
        .serial_clk_err_in (in_v[39]),
        .pll_lock_in       (in_v[38]),
        .over_temp_in      (in_v[37]),
        .over_curr_in      (in_v[36]),
        .vbat_low_short_in (in_v[35:32]),
        .chan1_faults_in   (in_v[7:0]),
        .chan2_faults_in   (in_v[15:8]),
        .chan3_faults_in   (in_v[23:16]),
        .chan4_faults_in   (in_v[31:24]),
        .reg_rd_in         (reg_rd_in),
        .reg_addr_in       (reg_addr_in),
        .reg_rdata_out     (reg_rdata_out),
        .reg_rvalid_out    (reg_rvalid_out)
    );

    // ------------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------------
    // Works out the byte a read of address a returns for stored levels s.
    function automatic lfs_pkg::lfs_byte_t exp_byte(input logic [7:0] a, input logic [39:0] s);
        case (a)
            `LFS_ADDR_GLOBAL: return {s[39:36], 4'h0};
            `LFS_ADDR_SUMMARY: return {|s[7:0], |s[15:8], |s[23:16], |s[31:24], 2'h0, |s[35:32], 1'h0};
            `LFS_ADDR_CHAN1: return s[7:0];
            default: return 8'h00;
        endcase
    endfunction

    // Drives one cycle, then models the edge and checks the outputs.
    task automatic step(input logic rst, input logic rd, input logic [7:0] a, input logic [39:0] v);
        rst_n_in = rst;
        reg_rd_in = rd;
        reg_addr_in = a;
        in_v = v;
        @(negedge ref_clk_in);
        // Reset clears the stored levels, read data and valid but not addr_m; otherwise a read uses levels from the cycle before.
        if (!rst) begin
            st_m = 40'h0;
            rdat_m = 8'h00;
            rv_m = 1'h0;
        end else begin
            rv_m = rd;
            if (rd) begin
                rdat_m = exp_byte(a, st_m);
                addr_m = a;
            end
            st_m = v;
        end
        `CHK("rvalid", reg_rvalid_out, rv_m)
        // The compare is picked by the register that was last read.
        if (!rst) begin
            `CHK("reset data", reg_rdata_out, 8'h00)
        end else if (addr_m == `LFS_ADDR_GLOBAL) begin
            `CHK("global", reg_rdata_out, rdat_m)
        end else if (addr_m == `LFS_ADDR_SUMMARY) begin
            `CHK("summary", reg_rdata_out, rdat_m)
        end else if (addr_m == `LFS_ADDR_CHAN1) begin
            `CHK("chan1", reg_rdata_out, rdat_m)
        end else begin
            `CHK("unmapped", reg_rdata_out, rdat_m)
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic test_done;
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    // Reset with every fault raised, a walking bit, then seeded traffic.
    initial begin
        for (int i = 0; i < 6; i++) begin
            step(1'h0, 1'h1, `LFS_ADDR_GLOBAL, 40'hFF_FFFF_FFFF);
        end
        // One fault at a time shows each field other than serial clock error lands in its own bit.
        for (int i = 0; i < 120; i++) begin
            step(1'h1, 1'h1, `LFS_ADDR_GLOBAL + 8'(i % 3), 40'h1 << (i / 3));
        end
        // Back-to-back random reads with sparse faults and rare resets.
        for (int i = 0; i < 2000; i++) begin
            ra = {$random(seed), $random(seed)};
            rb = {$random(seed), $random(seed)};
            if (i % 2 == 1) begin
                rb = rb & {$random(seed), $random(seed)};
            end
            ad = addr_tab[ra[42:40]];
            if (ra[47:44] == 4'h0) begin
                ad = ra[55:48];
            end
            step(rb[63:58] != 6'h0, ra[57:56] != 2'h0, ad, ra[39:0] & rb[39:0]);
        end
        test_done();
    end

    // Watchdog cuts a hang short well past the expected run length.
    initial begin
        repeat (3000) @(posedge ref_clk_in);
        err_count++;
        test_done();
    end

endmodule
